// ### ucrm_pkg.sv
// shared constants and carrier types for the uart channel register map
package ucrm_pkg;

	// channel count and register index width
	localparam int NCH   = 4;
	localparam int AW    = 3;

	// register index values on the index lines
	localparam logic [2:0] ADR_HOLD  = 3'h0; // rx/tx holding, divisor low
	localparam logic [2:0] ADR_MASK  = 3'h1; // interrupt mask, divisor high
	localparam logic [2:0] ADR_QCTL  = 3'h2; // status/queue, fraction, enhanced
	localparam logic [2:0] ADR_LCTL  = 3'h3; // line control, every bank
	localparam logic [2:0] ADR_MCTL  = 3'h4; // modem control, resume char 1
	localparam logic [2:0] ADR_LSTS  = 3'h5; // line status, resume char 2
	localparam logic [2:0] ADR_MSTS  = 3'h6; // modem status, pause char 1
	localparam logic [2:0] ADR_SCRT  = 3'h7; // scratch byte, pause char 2

	// field positions
	localparam int LCR_DIV_BIT   = 7; // divisor access
	localparam int EFR_ENH_BIT   = 4; // extended bits enable
	localparam int FCR_EN_BIT    = 0; // queues enabled
	localparam int FCR_RXRST_BIT = 1; // receive queue reset
	localparam int FCR_TXRST_BIT = 2; // transmit queue reset

	// key value of line control that opens the enhanced bank
	localparam logic [7:0] ENH_KEY    = 8'hbf;

	// masks of the bits gated by the extended enable, then other field masks
	localparam logic [7:0] IER_EXT    = 8'hf0;
	localparam logic [7:0] ISR_EXT    = 8'h30;
	localparam logic [7:0] FCR_EXT    = 8'h30;
	localparam logic [7:0] MCR_EXT    = 8'he0;
	localparam logic [7:0] ISR_FIFO   = 8'hc0; // queues-enabled pair
	localparam logic [7:0] FCR_RST    = 8'h06; // self-clearing reset pair
	localparam logic [7:0] DLD_USED   = 8'h3f; // bits 7-6 reserved

	// reset values
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_DLL    = 8'h01;

	// register banks chosen by line control
	typedef enum logic [1:0] {
		BANK_STD = 2'b00, // compatible set
		BANK_DIV = 2'b01, // baud divisor set
		BANK_ENH = 2'b10  // enhanced flow control set
	} ucrm_bank_e;

	// per-channel stored configuration
	typedef struct packed {
		logic [7:0] enhanced_feature;
		logic [7:0] divisor_fraction;
		logic [7:0] divisor_high;
		logic [7:0] dll;
		logic [7:0] queue_control;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] interrupt_mask;
		logic [7:0] scratch_byte;
		logic [7:0] xon1;
		logic [7:0] xon2;
		logic [7:0] xoff1;
		logic [7:0] xoff2;
	} ucrm_cfg_s;

	// per-channel state shown by the rest of the uart
	typedef struct packed {
		logic [7:0] rx_data;
		logic [7:0] interrupt_status;
		logic [7:0] line_status;
		logic [7:0] modem_status;
	} ucrm_stat_s;

	// per-channel one-cycle event pulses
	typedef struct packed {
		logic tx_load;
		logic rx_pop;
		logic rx_flush;
		logic tx_flush;
		logic msr_read;
	} ucrm_evt_s;

endpackage

// ### ucrm_top.sv
// register decoder and register map for the four channels of a quad uart
//
// Summary of operation
// - four channels, private register sets, chip select
// - index 0: read rx holding, write tx holding
// - divisor access, not key: divisor low/high bytes
// - index 2 fraction register when extended enabled
// - index 1 interrupt mask without divisor access
// - index 2: read status, write queue control
// - index 3 always reaches line control
// - indexes 4-7: modem, line, status, scratch
// - key value: enhanced, resume and pause chars
// - extended bits live only while enable set
// - enhanced feature register field layout
`timescale 1ns/1ns

module ucrm_top (
	// clock and reset
	input  wire logic                          I_REF_CLK,
	input  wire logic                          I_ARST_N,
	// host register port, synchronous strobes
	input  wire logic [ucrm_pkg::NCH-1:0]      I_CS_N,
	input  wire logic [ucrm_pkg::AW-1:0]       I_ADDR,
	input  wire logic                          I_WR,
	input  wire logic                          I_RD,
	input  wire logic [7:0]                    I_WDATA,
	// host read answer
	output logic [7:0]                         O_RDATA,
	output logic                               O_RVALID,
	// state of each channel from the uart core
	input  wire ucrm_pkg::ucrm_stat_s [ucrm_pkg::NCH-1:0] I_STAT,
	// configuration and events toward the uart core
	output ucrm_pkg::ucrm_cfg_s [ucrm_pkg::NCH-1:0]       O_CFG,
	output ucrm_pkg::ucrm_evt_s [ucrm_pkg::NCH-1:0]       O_EVT,
	output logic [7:0]                         O_TX_DATA
);

	// register map of one channel, by bank
	//   compatible, line control bit 7 low:
	//     0 rx/tx holding, 1 interrupt mask, 2 status read, queue control write,
	//     3 line control, 4 modem control, 5 line status, 6 modem status, 7 scratch
	//   divisor, bit 7 high and not the key value:
	//     0 divisor low, 1 divisor high, 2 fraction while extended bits are on,
	//     3 line control, 4 to 7 as in the compatible bank
	//   enhanced, line control equal to the key value:
	//     0 divisor low, 1 divisor high, 2 enhanced feature, 3 line control,
	//     4 and 5 resume chars, 6 and 7 pause chars
	// the key value has bit 7 set, so it is tested first

	// bank decode from line control, used per channel and by the read mux
	function automatic ucrm_pkg::ucrm_bank_e bank_of(input logic [7:0] line_control);
		ucrm_pkg::ucrm_bank_e b;
		b = ucrm_pkg::BANK_STD;
		if (line_control == ucrm_pkg::ENH_KEY) begin
			b = ucrm_pkg::BANK_ENH;
		end else if (line_control[ucrm_pkg::LCR_DIV_BIT]) begin
			b = ucrm_pkg::BANK_DIV;
		end
		return b;
	endfunction

	// the fraction needs both the divisor bank and the enable, and is
	// looked up on the write side and on the read side alike
	// fraction register reachable only in divisor bank with extension on
	function automatic logic frac_open(input ucrm_pkg::ucrm_cfg_s c);
		return (bank_of(c.line_control) == ucrm_pkg::BANK_DIV) && c.enhanced_feature[ucrm_pkg::EFR_ENH_BIT];
	endfunction

	// a select glitch that pulls two channels low at once must not write
	// both sets, so such a cycle is dropped whole and gets no read answer;
	// an access with no select low is ignored the same way
	// a strobe held high for two cycles counts as two accesses
	// channel select decode: exactly one select low is a valid access
	logic        sel_ok;                      // one and only one channel
	logic [1:0]  sel_idx;                     // index of that channel
	logic [2:0]  sel_cnt;                     // number of selects low

	// per channel register set and event pulses, then the shared answer
	// stored state
	ucrm_pkg::ucrm_cfg_s [ucrm_pkg::NCH-1:0] cfg_ff;     // register sets
	ucrm_pkg::ucrm_cfg_s [ucrm_pkg::NCH-1:0] nxt_cfg;
	ucrm_pkg::ucrm_evt_s [ucrm_pkg::NCH-1:0] evt_ff;     // event pulses
	ucrm_pkg::ucrm_evt_s [ucrm_pkg::NCH-1:0] nxt_evt;
	logic [7:0]                              tx_data_ff; // last tx byte
	logic [7:0]                              nxt_tx_data;
	logic [7:0]                              rdata_ff;   // read answer
	logic [7:0]                              nxt_rdata;
	logic                                    rvalid_ff;  // answer strobe
	logic                                    nxt_rvalid;

	// the index is that of the highest channel low; it is only used
	// when the count says exactly one is low
	// count selects and find the selected channel
	always_comb begin
		sel_cnt = 3'h0;
		sel_idx = 2'h0;
		for (int i = 0; i < ucrm_pkg::NCH; i++) begin
			if (!I_CS_N[i]) begin
				sel_cnt = sel_cnt + 3'h1;
				sel_idx = 2'(i);
			end
		end
		sel_ok = (sel_cnt == 3'h1);
	end

	// one private register set per channel
	// the sets never share storage; the only coupling between channels
	// is the hit decode on the shared host port
	genvar ch;
	generate
		for (ch = 0; ch < ucrm_pkg::NCH; ch++) begin : g_ch
			logic                 hit;    // this channel addressed
			ucrm_pkg::ucrm_bank_e bank;   // current bank of this channel

			assign hit  = sel_ok && (sel_idx == 2'(ch));
			assign bank = bank_of(cfg_ff[ch].line_control);

			// next register values and event pulses for this channel
			always_comb begin
				nxt_cfg[ch] = cfg_ff[ch];
				nxt_evt[ch] = '0;
				// start from the stored set, so an index without storage keeps
				// it, and from no events, so every pulse lasts one cycle
				// host write
				if (I_WR && hit) begin
					case (I_ADDR)
						ucrm_pkg::ADR_HOLD: begin
							if (bank == ucrm_pkg::BANK_STD) begin
								nxt_evt[ch].tx_load = 1'b1;
							end else begin
								nxt_cfg[ch].dll = I_WDATA;
							end
						end
						ucrm_pkg::ADR_MASK: begin
							if (bank == ucrm_pkg::BANK_STD) begin
								nxt_cfg[ch].interrupt_mask = I_WDATA;
							end else begin
								nxt_cfg[ch].divisor_high = I_WDATA;
							end
						end
						ucrm_pkg::ADR_QCTL: begin
							if (bank == ucrm_pkg::BANK_ENH) begin
								nxt_cfg[ch].enhanced_feature = I_WDATA;
							end else if (frac_open(cfg_ff[ch])) begin
								nxt_cfg[ch].divisor_fraction = I_WDATA & ucrm_pkg::DLD_USED;
							end else begin
								// queue control; reset bits only pulse
								// reset bits are not kept, so a later look at
								// the stored byte never shows a reset pending
								nxt_cfg[ch].queue_control = I_WDATA & ~ucrm_pkg::FCR_RST;
								nxt_evt[ch].rx_flush = I_WDATA[ucrm_pkg::FCR_RXRST_BIT];
								nxt_evt[ch].tx_flush = I_WDATA[ucrm_pkg::FCR_TXRST_BIT];
							end
						end
						ucrm_pkg::ADR_LCTL: begin
							// reachable in every bank: the only way back
							// out of the divisor and enhanced banks
							nxt_cfg[ch].line_control = I_WDATA;
						end
						ucrm_pkg::ADR_MCTL: begin
							if (bank == ucrm_pkg::BANK_ENH) begin
								nxt_cfg[ch].xon1 = I_WDATA;
							end else begin
								nxt_cfg[ch].modem_control = I_WDATA;
							end
						end
						ucrm_pkg::ADR_LSTS: begin
							// line status is owned by the core; write dropped outside the enhanced bank, where it sets xon2
							if (bank == ucrm_pkg::BANK_ENH) begin
								nxt_cfg[ch].xon2 = I_WDATA;
							end
						end
						ucrm_pkg::ADR_MSTS: begin
							// modem status is owned by the core; write dropped outside the enhanced bank, where it sets xoff1
							if (bank == ucrm_pkg::BANK_ENH) begin
								nxt_cfg[ch].xoff1 = I_WDATA;
							end
						end
						ucrm_pkg::ADR_SCRT: begin
							if (bank == ucrm_pkg::BANK_ENH) begin
								nxt_cfg[ch].xoff2 = I_WDATA;
							end else begin
								nxt_cfg[ch].scratch_byte = I_WDATA;
							end
						end
						// three index lines reach all eight items above
						default: begin
							nxt_cfg[ch] = cfg_ff[ch];
						end
					endcase
				end
				// reads move the core's queues: the holding read pops a byte
				// and the modem status read clears its change flags, so a
				// stray or repeated read strobe loses data
				// host read side effects
				if (I_RD && hit) begin
					if ((I_ADDR == ucrm_pkg::ADR_HOLD) && (bank == ucrm_pkg::BANK_STD)) begin
						nxt_evt[ch].rx_pop = 1'b1;
					end
					if ((I_ADDR == ucrm_pkg::ADR_MSTS) && (bank != ucrm_pkg::BANK_ENH)) begin
						nxt_evt[ch].msr_read = 1'b1;
					end
				end
				// the enable is taken from the next value, so a write that
				// turns it off clears the gated bits in that same cycle; the
				// stored bits are lost and must be written again later
				// the fraction means nothing without the enable: cleared whole
				// extended bits collapse to zero while the enable is off
				if (!nxt_cfg[ch].enhanced_feature[ucrm_pkg::EFR_ENH_BIT]) begin
					nxt_cfg[ch].interrupt_mask = nxt_cfg[ch].interrupt_mask & ~ucrm_pkg::IER_EXT;
					nxt_cfg[ch].queue_control = nxt_cfg[ch].queue_control & ~ucrm_pkg::FCR_EXT;
					nxt_cfg[ch].modem_control = nxt_cfg[ch].modem_control & ~ucrm_pkg::MCR_EXT;
					nxt_cfg[ch].divisor_fraction = ucrm_pkg::RST_ZERO;
				end
			end

			// divisor low leaves reset as one, so the baud divider never
			// sees a divide by zero before the host has set it up
			// register set and event flops of this channel
			always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
				if (!I_ARST_N) begin
					cfg_ff[ch].enhanced_feature   <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].divisor_fraction   <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].divisor_high   <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].dll   <= ucrm_pkg::RST_DLL;
					cfg_ff[ch].queue_control   <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].line_control   <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].modem_control   <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].interrupt_mask   <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].scratch_byte   <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].xon1  <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].xon2  <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].xoff1 <= ucrm_pkg::RST_ZERO;
					cfg_ff[ch].xoff2 <= ucrm_pkg::RST_ZERO;
					evt_ff[ch]       <= '0;
				end else begin
					cfg_ff[ch] <= nxt_cfg[ch];
					evt_ff[ch] <= nxt_evt[ch];
				end
			end
		end
	endgenerate

	// the read mux looks at the registered set, so a read and a write in
	// one cycle return the value from before the write
	// status from the core goes through as seen in the strobe cycle;
	// the core must hold it steady across that edge
	// with no valid select the mux still runs, but the strobe gate
	// throws its result away
	// read mux and transmit byte capture
	always_comb begin
		ucrm_pkg::ucrm_cfg_s  c;   // selected channel set
		ucrm_pkg::ucrm_stat_s s;   // selected channel state
		ucrm_pkg::ucrm_bank_e b;   // selected channel bank
		logic [7:0]           interrupt_status; // status with gated fields
		c = cfg_ff[sel_idx];
		s = I_STAT[sel_idx];
		b = bank_of(c.line_control);
		// status byte: the queue pair follows the stored enable, the
		// extended pair shows only while the extended enable is on
		interrupt_status = (s.interrupt_status & ~ucrm_pkg::ISR_FIFO)
			| ({8{c.queue_control[ucrm_pkg::FCR_EN_BIT]}} & ucrm_pkg::ISR_FIFO);
		if (!c.enhanced_feature[ucrm_pkg::EFR_ENH_BIT]) begin
			interrupt_status = interrupt_status & ~ucrm_pkg::ISR_EXT;
		end
		nxt_rdata   = rdata_ff;
		nxt_rvalid  = 1'b0;
		nxt_tx_data = tx_data_ff;
		// byte and load pulse leave on the same edge, so the core takes
		// the byte while the pulse stands and no later write overtakes it
		// byte for the transmit path, taken with its load pulse
		if (I_WR && sel_ok && (I_ADDR == ucrm_pkg::ADR_HOLD) && (b == ucrm_pkg::BANK_STD)) begin
			nxt_tx_data = I_WDATA;
		end
		// read answer, registered one cycle after the strobe
		if (I_RD && sel_ok) begin
			nxt_rvalid = 1'b1;
			case (I_ADDR)
				ucrm_pkg::ADR_HOLD: begin
					nxt_rdata = (b == ucrm_pkg::BANK_STD) ? s.rx_data : c.dll;
				end
				ucrm_pkg::ADR_MASK: begin
					nxt_rdata = (b == ucrm_pkg::BANK_STD) ? c.interrupt_mask : c.divisor_high;
				end
				ucrm_pkg::ADR_QCTL: begin
					if (b == ucrm_pkg::BANK_ENH) begin
						nxt_rdata = c.enhanced_feature;
					end else if (frac_open(c)) begin
						nxt_rdata = c.divisor_fraction & ucrm_pkg::DLD_USED;
					end else begin
						nxt_rdata = interrupt_status;
					end
				end
				ucrm_pkg::ADR_LCTL: begin
					nxt_rdata = c.line_control;
				end
				ucrm_pkg::ADR_MCTL: begin
					nxt_rdata = (b == ucrm_pkg::BANK_ENH) ? c.xon1 : c.modem_control;
				end
				ucrm_pkg::ADR_LSTS: begin
					nxt_rdata = (b == ucrm_pkg::BANK_ENH) ? c.xon2 : s.line_status;
				end
				ucrm_pkg::ADR_MSTS: begin
					nxt_rdata = (b == ucrm_pkg::BANK_ENH) ? c.xoff1 : s.modem_status;
				end
				ucrm_pkg::ADR_SCRT: begin
					nxt_rdata = (b == ucrm_pkg::BANK_ENH) ? c.xoff2 : c.scratch_byte;
				end
				default: begin
					nxt_rdata = ucrm_pkg::RST_ZERO;
				end
			endcase
		end
	end

	// read data keeps the last answer between reads; the strobe alone
	// marks it as new, for one cycle
	// the transmit byte likewise keeps the last holding write
	// shared answer and transmit byte flops
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rdata_ff   <= ucrm_pkg::RST_ZERO;
			rvalid_ff  <= 1'b0;
			tx_data_ff <= ucrm_pkg::RST_ZERO;
		end else begin
			rdata_ff   <= nxt_rdata;
			rvalid_ff  <= nxt_rvalid;
			tx_data_ff <= nxt_tx_data;
		end
	end

	// no output passes through logic after its flop, so the core and
	// the host see clean levels from the clock edge on
	// outputs straight from flops
	assign O_RDATA   = rdata_ff;
	assign O_RVALID  = rvalid_ff;
	assign O_CFG     = cfg_ff;
	assign O_EVT     = evt_ff;
	assign O_TX_DATA = tx_data_ff;

endmodule

// ### ucrm_top_sva.sv
// assertion checker for the channel register map
`timescale 1ns/1ns
module ucrm_top_sva (
	// clock and reset
	input logic	I_REF_CLK,
	input logic	I_ARST_N,
	// host port
	input logic [ucrm_pkg::NCH-1:0]	I_CS_N,
	input logic [ucrm_pkg::AW-1:0]	I_ADDR,
	input logic	I_WR,
	input logic	I_RD,
	input logic [7:0]	I_WDATA,
	input logic [7:0]	O_RDATA,
	input logic	O_RVALID,
	// core side
	input ucrm_pkg::ucrm_stat_s [ucrm_pkg::NCH-1:0]	I_STAT,
	input ucrm_pkg::ucrm_cfg_s [ucrm_pkg::NCH-1:0]	O_CFG,
	input ucrm_pkg::ucrm_evt_s [ucrm_pkg::NCH-1:0]	O_EVT,
	input logic [7:0]	O_TX_DATA
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_ARST_N);
	// channel zero selected alone
	logic	c0;
	assign c0 = (I_CS_N == 4'he);
	AST_RD_ANSWER: assert property (I_RD && $onehot(~I_CS_N) |=> O_RVALID)
		else $error("read not answered");
	AST_NO_SELECT: assert property (!(I_RD && $onehot(~I_CS_N)) |=> !O_RVALID)
		else $error("answer without a read");
	AST_OTHER_CH: assert property (c0 |=> $stable(O_CFG[1]))
		else $error("other channel changed");
	AST_LCR_WR: assert property (I_WR && c0 && I_ADDR == 3'h3
		|=> O_CFG[0].line_control == $past(I_WDATA)) else $error("line control not written");
	AST_TX_LOAD: assert property (I_WR && c0 && I_ADDR == 3'h0 && !O_CFG[0].line_control[7]
		|=> O_EVT[0].tx_load && O_TX_DATA == $past(I_WDATA)) else $error("tx load wrong");
	AST_RX_POP: assert property (I_RD && c0 && I_ADDR == 3'h0 && !O_CFG[0].line_control[7]
		|=> O_EVT[0].rx_pop && O_RDATA == $past(I_STAT[0].rx_data)) else $error("rx pop wrong");
	AST_EFR_KEY: assert property (I_WR && c0 && I_ADDR == 3'h2 && O_CFG[0].line_control == 8'hbf
		|=> O_CFG[0].enhanced_feature == $past(I_WDATA)) else $error("enhanced not written");
	AST_EXT_OFF: assert property (!O_CFG[0].enhanced_feature[4] ##1 !O_CFG[0].enhanced_feature[4] |->
		O_CFG[0].interrupt_mask[7:4] == 4'h0 && O_CFG[0].queue_control[5:4] == 2'h0 && O_CFG[0].modem_control[7:5] == 3'h0
		&& O_CFG[0].divisor_fraction == 8'h00) else $error("extended bits live");
	AST_DLD_RSVD: assert property (O_CFG[0].divisor_fraction[7:6] == 2'h0)
		else $error("fraction reserved bits set");
	AST_FCR_FLUSH: assert property (I_WR && c0 && I_ADDR == 3'h2 && !O_CFG[0].line_control[7]
		|=> O_EVT[0].rx_flush == $past(I_WDATA[1]) && O_EVT[0].tx_flush == $past(I_WDATA[2])
		&& O_CFG[0].queue_control[2:1] == 2'h0) else $error("queue control write wrong");
	AST_MSR_READ: assert property (I_RD && c0 && I_ADDR == 3'h6 && O_CFG[0].line_control != 8'hbf
		|=> O_EVT[0].msr_read) else $error("modem status read not flagged");
endmodule

bind ucrm_top ucrm_top_sva i_ucrm_top_sva (.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N),
	.I_CS_N(I_CS_N), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD), .I_WDATA(I_WDATA),
	.O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_STAT(I_STAT), .O_CFG(O_CFG),
	.O_EVT(O_EVT), .O_TX_DATA(O_TX_DATA));

// ### ucrm_core_stub.sv
// stand-in for the uart core: per-channel status levels
`timescale 1ns/1ns
module ucrm_core_stub (
	// status toward the register map
	output ucrm_pkg::ucrm_stat_s [ucrm_pkg::NCH-1:0]	o_stat
);
	// distinct per channel except interrupt status, a shared f5 whose high bits are set to expose masking
	always_comb begin
		for (int c = 0; c < ucrm_pkg::NCH; c++) begin
			o_stat[c] = {8'ha0 + 8'(c), 8'hf5, 8'h60 + 8'(c), 8'h10 + 8'(c)};
		end
	end
endmodule

// ### tb_top.sv
// self-checking bench for the channel register map
`timescale 1ns/1ns
module tb_top;
	// host port drive
	logic	clk = 1'b0;
	logic	arst_n = 1'b0;
	logic [3:0]	cs_n = 4'hf;
	logic [2:0]	addr = 3'h0;
	logic	wr = 1'b0;
	logic	rd = 1'b0;
	logic [7:0]	wdata = 8'h00;
	// design outputs and core status
	logic [7:0]	rdata;
	logic	rvalid;
	logic [7:0]	tx_data;
	ucrm_pkg::ucrm_stat_s [3:0]	stat;
	ucrm_pkg::ucrm_cfg_s [3:0]	cfg;
	ucrm_pkg::ucrm_evt_s [3:0]	evt;
	// run counters
	int	fail_count = 0;
	int	checks = 0;

	// 10 mhz clock
	always #50 clk = ~clk;

	ucrm_core_stub i_ucrm_core_stub (.o_stat(stat));
	ucrm_top i_ucrm_top (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_CS_N(cs_n), .I_ADDR(addr),
		.I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid),
		.I_STAT(stat), .O_CFG(cfg), .O_EVT(evt), .O_TX_DATA(tx_data));

	// compare seen against expected
	task automatic chk(input logic [103:0] seen, input logic [103:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one access held one cycle; outputs looked at after the taking edge
	task automatic acc(input logic [3:0] s, input logic [2:0] a, input logic w,
		input logic [7:0] d);
		@(posedge clk);
		cs_n <= s;
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		@(posedge clk);
		cs_n <= 4'hf;
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
	endtask

	// write one channel register
	task automatic wrt(input logic [1:0] c, input logic [2:0] a, input logic [7:0] d);
		acc(~(4'h1 << c), a, 1'b1, d);
	endtask

	// read one channel register and compare
	task automatic rdc(input logic [1:0] c, input logic [2:0] a, input logic [7:0] e);
		acc(~(4'h1 << c), a, 1'b0, 8'h00);
		chk(104'({rvalid, rdata}), 104'({1'b1, e}));
	endtask

	// end-of-test line
	task automatic done(input string n);
		$display("test %s finished, %0d checks so far", n, checks);
	endtask

	// counts and verdict
	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hang guard, far beyond the hundred or so cycles needed
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		close_out();
	end

	// test sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		for (int c = 0; c < 4; c++) begin
			chk(cfg[c], 104'h01 << 72);
		end
		chk(104'({rdata, tx_data, rvalid, evt}), 104'h0);
		done("reset");
		for (int c = 0; c < 4; c++) begin
			wrt(c[1:0], 3'h7, 8'h50 + 8'(c));
		end
		acc(4'hc, 3'h7, 1'b1, 8'hee);
		acc(4'hc, 3'h7, 1'b0, 8'h00);
		chk(104'(rvalid), 104'h0);
		for (int c = 0; c < 4; c++) begin
			rdc(c[1:0], 3'h7, 8'h50 + 8'(c));
		end
		done("channels");
		wrt(2'h0, 3'h3, 8'h80);
		rdc(2'h0, 3'h3, 8'h80);
		wrt(2'h0, 3'h0, 8'h34);
		chk(104'({tx_data, evt[0]}), 104'h0);
		wrt(2'h0, 3'h1, 8'h12);
		rdc(2'h0, 3'h0, 8'h34);
		rdc(2'h0, 3'h1, 8'h12);
		rdc(2'h0, 3'h2, 8'h05);
		done("divisor");
		wrt(2'h0, 3'h3, 8'hbf);
		wrt(2'h0, 3'h2, 8'h10);
		for (int a = 4; a < 8; a++) begin
			wrt(2'h0, a[2:0], 8'hc0 + 8'(a));
		end
		for (int a = 4; a < 8; a++) begin
			rdc(2'h0, a[2:0], 8'hc0 + 8'(a));
		end
		rdc(2'h0, 3'h2, 8'h10);
		rdc(2'h0, 3'h0, 8'h34);
		done("enhanced");
		wrt(2'h0, 3'h3, 8'h80);
		wrt(2'h0, 3'h2, 8'hff);
		rdc(2'h0, 3'h2, 8'h3f);
		wrt(2'h0, 3'h3, 8'h03);
		wrt(2'h0, 3'h1, 8'hff);
		rdc(2'h0, 3'h1, 8'hff);
		wrt(2'h0, 3'h2, 8'h07);
		chk(104'(cfg[0].queue_control), 104'h01);
		chk(104'(evt[0]), 104'h06);
		rdc(2'h0, 3'h2, 8'hf5);
		wrt(2'h0, 3'h5, 8'h00);
		rdc(2'h0, 3'h5, 8'h60);
		rdc(2'h0, 3'h6, 8'h10);
		chk(104'(evt[0]), 104'h01);
		wrt(2'h0, 3'h4, 8'hff);
		rdc(2'h0, 3'h4, 8'hff);
		wrt(2'h0, 3'h0, 8'ha5);
		chk(104'({tx_data, evt[0]}), 104'({8'ha5, 5'h10}));
		@(negedge clk);
		chk(104'({tx_data, evt[0]}), 104'({8'ha5, 5'h00}));
		rdc(2'h0, 3'h0, 8'ha0);
		chk(104'(evt[0]), 104'h08);
		done("standard");
		wrt(2'h0, 3'h3, 8'hbf);
		wrt(2'h0, 3'h2, 8'h00);
		wrt(2'h0, 3'h3, 8'h03);
		rdc(2'h0, 3'h1, 8'h0f);
		rdc(2'h0, 3'h4, 8'h1f);
		rdc(2'h0, 3'h2, 8'hc5);
		done("extended off");
		close_out();
	end
endmodule
